// ==== hw/eps_defines.vh ====
`ifndef EPS_DEFINES_VH
`define EPS_DEFINES_VH

// ----------------------------------------
// bus geometry
// ----------------------------------------
`define EPS_ADDR_W 4
`define EPS_DATA_W 16
`define EPS_ZERO16 16'h0000

// ----------------------------------------
// register offsets
// ----------------------------------------
`define EPS_REG_STATUS 4'h0
`define EPS_REG_CTRL 4'h1
`define EPS_REG_EVT 4'h2
`define EPS_REG_MASK 4'h3

// ----------------------------------------
// status word bit positions
// ----------------------------------------
`define EPS_B_LINK 0
`define EPS_B_SPEED 1
`define EPS_B_DUPLEX 3
`define EPS_B_ANEG 4
`define EPS_B_BOOTP_VLD 8
`define EPS_B_DHCP_VLD 9
`define EPS_B_BOOTP_SEL 10
`define EPS_B_DHCP_SEL 11
`define EPS_B_ADV100FD 12
`define EPS_B_ADV100HD 13
`define EPS_B_ADV10FD 14
`define EPS_STATUS_RST 16'h0000

// ----------------------------------------
// control register bit positions
// ----------------------------------------
`define EPS_C_ANEG 0
`define EPS_C_BOOTP 1
`define EPS_C_DHCP 2
`define EPS_C_ADV100FD 3
`define EPS_C_ADV100HD 4
`define EPS_C_ADV10FD 5
`define EPS_CTRL_W 6
`define EPS_CTRL_RST 6'h00

// ----------------------------------------
// event bit positions
// ----------------------------------------
`define EPS_E_LINK 0
`define EPS_E_SPEED 1
`define EPS_E_DUPLEX 2
`define EPS_E_BOOTP 3
`define EPS_E_DHCP 4
`define EPS_EVT_W 5
`define EPS_EVT_RST 5'h00

`endif

// ==== hw/eps_sync.v ====
`timescale 1ns/1ps
module eps_sync (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // asynchronous level in, clean level out
  input wire din,
  output reg dout_q
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // a change only counts once two later stages agree
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout_q <= s3_q;
      end
    end
  end

endmodule

// ==== hw/eps_irq.v ====
`timescale 1ns/1ps
`include "eps_defines.vh"
module eps_irq (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // event pulses
  input wire [`EPS_EVT_W-1:0] evt_set,
  // software access
  input wire evt_clr_wr,
  input wire mask_wr,
  input wire [`EPS_EVT_W-1:0] wr_bits,
  // state
  output reg [`EPS_EVT_W-1:0] evt_q,
  output reg [`EPS_EVT_W-1:0] mask_q,
  output wire irq
);

  wire [`EPS_EVT_W-1:0] clr = evt_clr_wr ? wr_bits : `EPS_EVT_RST;
  // set beats a same-cycle clear so no event is lost
  wire [`EPS_EVT_W-1:0] evt_d = (evt_q & ~clr) | evt_set;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      evt_q <= `EPS_EVT_RST;
      mask_q <= `EPS_EVT_RST;
    end else begin
      evt_q <= evt_d;
      if (mask_wr) begin
        mask_q <= wr_bits;
      end
    end
  end

  assign irq = |(evt_q & mask_q);

endmodule

// ==== hw/eps_status.v ====
`timescale 1ns/1ps
`include "eps_defines.vh"
module eps_status (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // register port
  input wire [`EPS_ADDR_W-1:0] reg_addr,
  input wire [`EPS_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`EPS_DATA_W-1:0] reg_rdata_q,
  // phy link indications, asynchronous
  input wire phy_link_up,
  input wire phy_speed_100,
  input wire phy_full_duplex,
  // address acquisition logic, same clock
  input wire bootp_resp_ok,
  input wire dhcp_resp_ok,
  // configuration towards mac, phy and acquisition logic
  output wire aneg_en,
  output wire bootp_sel,
  output wire dhcp_sel,
  output wire adv_100fd,
  output wire adv_100hd,
  output wire adv_10fd,
  // status
  output reg [`EPS_DATA_W-1:0] status_word_q,
  output wire net_params_valid,
  output wire irq
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function hit;
    input [`EPS_ADDR_W-1:0] addr;
    input [`EPS_ADDR_W-1:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  function changed;
    input cur;
    input prev;
    begin
      changed = cur ^ prev;
    end
  endfunction

  function rose;
    input cur;
    input prev;
    begin
      rose = cur & ~prev;
    end
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  wire link_s;
  wire speed_s;
  wire duplex_s;
  reg [`EPS_CTRL_W-1:0] ctrl_q;
  reg [`EPS_CTRL_W-1:0] ctrl_d;
  reg bootp_vld_q;
  reg bootp_vld_d;
  reg dhcp_vld_q;
  reg dhcp_vld_d;
  reg link_prev_q;
  reg speed_prev_q;
  reg duplex_prev_q;
  reg bootp_vld_prev_q;
  reg dhcp_vld_prev_q;
  reg [`EPS_DATA_W-1:0] status_d;
  reg [`EPS_DATA_W-1:0] rdata_d;
  reg [`EPS_EVT_W-1:0] evt_set;
  wire [`EPS_EVT_W-1:0] evt_q;
  wire [`EPS_EVT_W-1:0] mask_q;
  wire wr_ctrl;
  wire wr_evt;
  wire wr_mask;
  wire [`EPS_CTRL_W-1:0] ctrl_wr_bits;
  wire both_methods;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  eps_sync u_sync_link (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .din(phy_link_up),
    .dout_q(link_s)
  );

  eps_sync u_sync_speed (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .din(phy_speed_100),
    .dout_q(speed_s)
  );

  eps_sync u_sync_duplex (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .din(phy_full_duplex),
    .dout_q(duplex_s)
  );

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  // no write path reaches the status word, so it stays read-only
  assign wr_ctrl = reg_wr & hit(reg_addr, `EPS_REG_CTRL);
  assign wr_evt = reg_wr & hit(reg_addr, `EPS_REG_EVT);
  assign wr_mask = reg_wr & hit(reg_addr, `EPS_REG_MASK);
  assign ctrl_wr_bits = reg_wdata[`EPS_CTRL_W-1:0];
  assign both_methods = ctrl_wr_bits[`EPS_C_BOOTP] & ctrl_wr_bits[`EPS_C_DHCP];

  // ----------------------------------------
  // control register
  // ----------------------------------------
  // only one address method at a time; a write asking for
  // both keeps the old method bits and takes the rest
  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = ctrl_wr_bits;
      if (both_methods) begin
        ctrl_d[`EPS_C_BOOTP] = ctrl_q[`EPS_C_BOOTP];
        ctrl_d[`EPS_C_DHCP] = ctrl_q[`EPS_C_DHCP];
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q <= `EPS_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  assign aneg_en = ctrl_q[`EPS_C_ANEG];
  assign bootp_sel = ctrl_q[`EPS_C_BOOTP];
  assign dhcp_sel = ctrl_q[`EPS_C_DHCP];
  assign adv_100fd = ctrl_q[`EPS_C_ADV100FD];
  assign adv_100hd = ctrl_q[`EPS_C_ADV100HD];
  assign adv_10fd = ctrl_q[`EPS_C_ADV10FD];

  // ----------------------------------------
  // address acquisition valid flags
  // ----------------------------------------
  // a flag only lives while its method is selected, so a stale
  // answer can never vouch for a newly chosen method
  always @* begin
    bootp_vld_d = bootp_vld_q;
    if (!bootp_sel) begin
      bootp_vld_d = 1'b0;
    end else if (bootp_resp_ok) begin
      bootp_vld_d = 1'b1;
    end
  end

  always @* begin
    dhcp_vld_d = dhcp_vld_q;
    if (!dhcp_sel) begin
      dhcp_vld_d = 1'b0;
    end else if (dhcp_resp_ok) begin
      dhcp_vld_d = 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      bootp_vld_q <= 1'b0;
      dhcp_vld_q <= 1'b0;
    end else begin
      bootp_vld_q <= bootp_vld_d;
      dhcp_vld_q <= dhcp_vld_d;
    end
  end

  // static addressing counts as valid at once
  assign net_params_valid = ~(bootp_sel & ~bootp_vld_q)
                          & ~(dhcp_sel & ~dhcp_vld_q);

  // ----------------------------------------
  // status fields
  // ----------------------------------------
  wire fld_link;
  wire fld_speed;
  wire fld_duplex;
  wire fld_aneg;
  wire fld_bootp_vld;
  wire fld_dhcp_vld;
  wire fld_bootp_sel;
  wire fld_dhcp_sel;
  wire fld_adv_100fd;
  wire fld_adv_100hd;
  wire fld_adv_10fd;

  assign fld_link = link_s;
  assign fld_speed = speed_s;
  assign fld_duplex = duplex_s;
  assign fld_aneg = aneg_en;
  assign fld_bootp_vld = bootp_vld_q;
  assign fld_dhcp_vld = dhcp_vld_q;
  assign fld_bootp_sel = bootp_sel;
  assign fld_dhcp_sel = dhcp_sel;
  // offers show in the status word only while negotiating and read zero there otherwise; adv_* outputs and the control view are not gated
  assign fld_adv_100fd = aneg_en & adv_100fd;
  assign fld_adv_100hd = aneg_en & adv_100hd;
  assign fld_adv_10fd = aneg_en & adv_10fd;

  // ----------------------------------------
  // status word
  // ----------------------------------------
  always @* begin
    status_d = `EPS_STATUS_RST;
    status_d[`EPS_B_LINK] = fld_link;
    status_d[`EPS_B_SPEED] = fld_speed;
    status_d[`EPS_B_DUPLEX] = fld_duplex;
    status_d[`EPS_B_ANEG] = fld_aneg;
    status_d[`EPS_B_BOOTP_VLD] = fld_bootp_vld;
    status_d[`EPS_B_DHCP_VLD] = fld_dhcp_vld;
    status_d[`EPS_B_BOOTP_SEL] = fld_bootp_sel;
    status_d[`EPS_B_DHCP_SEL] = fld_dhcp_sel;
    status_d[`EPS_B_ADV100FD] = fld_adv_100fd;
    status_d[`EPS_B_ADV100HD] = fld_adv_100hd;
    status_d[`EPS_B_ADV10FD] = fld_adv_10fd;
  end

  // fed only from port state, never from the write port
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      status_word_q <= `EPS_STATUS_RST;
    end else begin
      status_word_q <= status_d;
    end
  end

  // ----------------------------------------
  // events
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      link_prev_q <= 1'b0;
      speed_prev_q <= 1'b0;
      duplex_prev_q <= 1'b0;
      bootp_vld_prev_q <= 1'b0;
      dhcp_vld_prev_q <= 1'b0;
    end else begin
      link_prev_q <= link_s;
      speed_prev_q <= speed_s;
      duplex_prev_q <= duplex_s;
      bootp_vld_prev_q <= bootp_vld_q;
      dhcp_vld_prev_q <= dhcp_vld_q;
    end
  end

  always @* begin
    evt_set = `EPS_EVT_RST;
    evt_set[`EPS_E_LINK] = changed(link_s, link_prev_q);
    evt_set[`EPS_E_SPEED] = changed(speed_s, speed_prev_q);
    evt_set[`EPS_E_DUPLEX] = changed(duplex_s, duplex_prev_q);
    evt_set[`EPS_E_BOOTP] = rose(bootp_vld_q, bootp_vld_prev_q);
    evt_set[`EPS_E_DHCP] = rose(dhcp_vld_q, dhcp_vld_prev_q);
  end

  eps_irq u_irq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .evt_set(evt_set),
    .evt_clr_wr(wr_evt),
    .mask_wr(wr_mask),
    .wr_bits(reg_wdata[`EPS_EVT_W-1:0]),
    .evt_q(evt_q),
    .mask_q(mask_q),
    .irq(irq)
  );

  // ----------------------------------------
  // read views
  // ----------------------------------------
  // unused upper bits read zero
  wire [`EPS_DATA_W-1:0] ctrl_view;
  wire [`EPS_DATA_W-1:0] evt_view;
  wire [`EPS_DATA_W-1:0] mask_view;

  assign ctrl_view = {{(`EPS_DATA_W-`EPS_CTRL_W){1'b0}}, ctrl_q};
  assign evt_view = {{(`EPS_DATA_W-`EPS_EVT_W){1'b0}}, evt_q};
  assign mask_view = {{(`EPS_DATA_W-`EPS_EVT_W){1'b0}}, mask_q};

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always @* begin
    rdata_d = `EPS_ZERO16;
    if (reg_rd) begin
      case (reg_addr)
        `EPS_REG_STATUS: begin
          rdata_d = status_word_q;
        end
        `EPS_REG_CTRL: begin
          rdata_d = ctrl_view;
        end
        `EPS_REG_EVT: begin
          rdata_d = evt_view;
        end
        `EPS_REG_MASK: begin
          rdata_d = mask_view;
        end
        default: begin
          rdata_d = `EPS_ZERO16;
        end
      endcase
    end
  end

  // data stands only in the cycle after the read strobe
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata_q <= `EPS_ZERO16;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

endmodule

// ==== verif/eps_status_assertions.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// port status word checker
// ----------------------------------------
module eps_status_chk (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // register port
  input wire [3:0] reg_addr,
  input wire reg_rd,
  input wire [15:0] reg_rdata_q,
  // pins and answers
  input wire phy_link_up,
  input wire phy_speed_100,
  input wire phy_full_duplex,
  input wire bootp_resp_ok,
  input wire dhcp_resp_ok,
  // configuration and status
  input wire aneg_en,
  input wire bootp_sel,
  input wire dhcp_sel,
  input wire adv_100fd,
  input wire adv_100hd,
  input wire adv_10fd,
  input wire [15:0] status_word_q,
  input wire net_params_valid,
  input wire irq
);
  wire [2:0] pins = {phy_full_duplex, phy_speed_100, phy_link_up};
  wire [2:0] adv = {adv_10fd, adv_100hd, adv_100fd};
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  chk_resv_zero: assert property (
    status_word_q[2] == 1'b0 && status_word_q[7:5] == 3'h0 && status_word_q[15] == 1'b0)
    else $error("reserved status bit set");
  // pins pass a three-stage synchroniser, so allow a settled window first
  chk_pins_follow: assert property (
    $stable(pins) [*5] |-> {status_word_q[3], status_word_q[1:0]} == pins)
    else $error("link bits differ from settled pins");
  chk_aneg_bit: assert property (
    status_word_q[4] == $past(aneg_en))
    else $error("autonegotiation bit wrong");
  chk_adv_gated: assert property (
    status_word_q[14:12] == ($past(adv) & {3{$past(aneg_en)}}))
    else $error("advertisement bits wrong");
  chk_method_sel: assert property (
    status_word_q[11:10] == $past({dhcp_sel, bootp_sel}))
    else $error("method bits wrong");
  chk_bootp_set: assert property (
    bootp_resp_ok && bootp_sel |-> ##2 status_word_q[8])
    else $error("bootp flag not set");
  chk_bootp_cause: assert property (
    $rose(status_word_q[8]) |-> $past(bootp_resp_ok, 2))
    else $error("bootp flag rose without answer");
  chk_dhcp_set: assert property (
    dhcp_resp_ok && dhcp_sel |-> ##2 status_word_q[9])
    else $error("dhcp flag not set");
  chk_dhcp_cause: assert property (
    $rose(status_word_q[9]) |-> $past(dhcp_resp_ok, 2))
    else $error("dhcp flag rose without answer");
  chk_params_bad: assert property (
    bootp_sel && !status_word_q[8] && !$past(bootp_resp_ok) |-> !net_params_valid)
    else $error("parameters valid before answer");
  chk_rd_status: assert property (
    reg_rd && reg_addr == 4'h0 |=> reg_rdata_q == $past(status_word_q))
    else $error("status read returned wrong word");
  chk_rd_idle: assert property (
    !reg_rd |=> reg_rdata_q == 16'h0000)
    else $error("read data outside read slot");

  cover property (status_word_q[8]);
  cover property (status_word_q[9]);
  cover property (irq);
endmodule

bind eps_status eps_status_chk eps_status_chk_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .phy_link_up(phy_link_up), .phy_speed_100(phy_speed_100),
  .phy_full_duplex(phy_full_duplex), .bootp_resp_ok(bootp_resp_ok),
  .dhcp_resp_ok(dhcp_resp_ok), .aneg_en(aneg_en), .bootp_sel(bootp_sel),
  .dhcp_sel(dhcp_sel), .adv_100fd(adv_100fd), .adv_100hd(adv_100hd),
  .adv_10fd(adv_10fd), .status_word_q(status_word_q),
  .net_params_valid(net_params_valid), .irq(irq));

// ==== verif/test_eps_status.sv ====
`timescale 1ns/1ps
module test_eps_status;
  reg ref_clk;
  reg rst_n;
  reg [3:0] reg_addr;
  reg [15:0] reg_wdata;
  reg reg_wr;
  reg reg_rd;
  reg [2:0] pins;
  reg bootp_resp_ok;
  reg dhcp_resp_ok;
  wire [15:0] reg_rdata_q;
  wire [15:0] status_word_q;
  wire net_params_valid;
  wire irq;
  wire [5:0] cfg;
  integer n_errors;
  integer checked;
  integer i;

  eps_status eps_status_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .phy_link_up(pins[0]), .phy_speed_100(pins[1]), .phy_full_duplex(pins[2]),
    .bootp_resp_ok(bootp_resp_ok), .dhcp_resp_ok(dhcp_resp_ok), .aneg_en(cfg[0]),
    .bootp_sel(cfg[1]), .dhcp_sel(cfg[2]), .adv_100fd(cfg[3]), .adv_100hd(cfg[4]),
    .adv_10fd(cfg[5]),
    .status_word_q(status_word_q), .net_params_valid(net_params_valid), .irq(irq));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // p = {duplex, speed, link}, c = control bits, v = {dhcp, bootp} valid
  function [15:0] ew(input [2:0] p, input [5:0] c, input [1:0] v);
    ew = {1'b0, c[5:3] & {3{c[0]}}, c[2:1], v, 3'h0, c[0], p[2], 1'b0, p[1:0]};
  endfunction

  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask

  task wrap_up;
    begin
      $display("errors %0d, comparisons %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  task wr(input [3:0] a, input [15:0] d);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
    end
  endtask

  // data stand only in the cycle after the read edge
  task rd(input [3:0] a, input [15:0] e);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata_q, e);
    end
  endtask

  task resp(input b, input d);
    begin
      @(posedge ref_clk);
      bootp_resp_ok <= b;
      dhcp_resp_ok <= d;
      @(posedge ref_clk);
      bootp_resp_ok <= 1'b0;
      dhcp_resp_ok <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    begin
      chk(status_word_q, 16'h0000);
      chk(net_params_valid, 1'b1);
      rd(4'h0, 16'h0000);
    end
  endtask

  task t_pins;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        @(posedge ref_clk);
        pins <= i[2:0];
        repeat (5) @(posedge ref_clk);
        rd(4'h0, ew(i[2:0], 6'h00, 2'b00));
      end
      chk(irq, 1'b0);
    end
  endtask

  // adv bits with and without autonegotiation, each method alone
  task t_ctrl;
    reg [29:0] tbl;
    reg [5:0] c;
    begin
      tbl = {6'h39, 6'h38, 6'h02, 6'h04, 6'h00};
      for (i = 0; i < 5; i = i + 1) begin
        c = tbl[i*6 +: 6];
        wr(4'h1, {10'h000, c});
        rd(4'h0, ew(3'h7, c, 2'b00));
        rd(4'h1, {10'h000, c});
        chk(cfg, c);
      end
      // both methods at once is refused, the rest is taken
      wr(4'h1, 16'h0007);
      rd(4'h1, 16'h0001);
      chk(cfg, 6'h01);
      rd(4'h0, ew(3'h7, 6'h01, 2'b00));
    end
  endtask

  task t_valid;
    begin
      wr(4'h1, 16'h0002);
      rd(4'h0, ew(3'h7, 6'h02, 2'b00));
      chk(net_params_valid, 1'b0);
      // dhcp answer while unselected must be dropped
      resp(1'b1, 1'b1);
      rd(4'h0, ew(3'h7, 6'h02, 2'b01));
      chk(net_params_valid, 1'b1);
      wr(4'h1, 16'h0004);
      @(posedge ref_clk);
      rd(4'h0, ew(3'h7, 6'h04, 2'b00));
      chk(net_params_valid, 1'b0);
      resp(1'b0, 1'b1);
      rd(4'h0, ew(3'h7, 6'h04, 2'b10));
      chk(net_params_valid, 1'b1);
    end
  endtask

  task t_ro;
    begin
      wr(4'h0, 16'hffff);
      rd(4'h0, ew(3'h7, 6'h04, 2'b10));
      rd(4'h9, 16'h0000);
    end
  endtask

  task t_irq;
    begin
      wr(4'h2, 16'h001f);
      wr(4'h3, 16'h0001);
      #1;
      chk(irq, 1'b0);
      @(posedge ref_clk);
      pins <= 3'h6;
      repeat (6) @(posedge ref_clk);
      #1;
      chk(irq, 1'b1);
      rd(4'h2, 16'h0001);
      rd(4'h3, 16'h0001);
      wr(4'h2, 16'h0001);
      #1;
      chk(irq, 1'b0);
      rd(4'h0, ew(3'h6, 6'h04, 2'b10));
    end
  endtask

  // ----------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pins = 3'h0;
    bootp_resp_ok = 1'b0;
    dhcp_resp_ok = 1'b0;
    n_errors = 0;
    checked = 0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    t_reset;
    t_pins;
    t_ctrl;
    t_valid;
    t_ro;
    t_irq;
    wrap_up;
  end

  // whole sequence needs about 160 cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors = n_errors + 1;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up;
  end
endmodule
